// ### design/dio_cfg.svh
// Constants for the motion controller digital I/O block
`ifndef DIO_CFG_SVH
`define DIO_CFG_SVH
`define AUX_BASE_INDEX     7'h51
`define AUX_LAST_INDEX     7'h60
`define AUX_FIRST_A_INDEX  7'h51
`define AUX_FIRST_B_INDEX  7'h52
`define BANK_WIDTH         8
`define SECOND_BANK_AXES   4'h5
`define STROBE_PULSE_NS     600
`define CLK_PERIOD_NS       10
`define STROBE_PULSE_CYCLES ((`STROBE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define EXT_POINTS         40
`define EXT_GROUPS         5
`define OUT_RESET          8'h00
`endif

// ### design/dio_pkg.sv
// Types for the motion controller digital I/O block
package dio_pkg;
	typedef enum logic [1:0] {
		out_raise,
		out_lower,
		out_write_bit,
		out_write_bank
	} out_op_t;

	typedef struct packed {
		logic       valid;
		out_op_t    op;
		logic       bank;
		logic [2:0] bit_sel;
		logic [7:0] data;
	} out_cmd_t;

	typedef enum logic {
		cmp_incremental,
		cmp_one_shot
	} cmp_mode_t;

	typedef struct packed {
		logic        arm;
		cmp_mode_t   mode;
		logic [2:0]  axis_sel;
		logic [31:0] point;
		logic [31:0] increment;
	} cmp_cfg_t;
endpackage

// ### design/motion_ctrl_digital_io.sv
// Digital I/O block: aux inputs, general outputs, compare, error, extended bank
`timescale 1ns/10ps
`include "dio_cfg.svh"

// Behaviour
// R1 - Aux encoder A/B exposed as inputs 81-96
// R2 - First axis: A is 81, B is 82
// R3 - Stepper axes hide their aux inputs
// R4 - Eight outputs: raise, lower, write, bank, readback
// R5 - Second bank present with five or more axes
// R6 - Compare: 600 ns low pulse or one-shot
// R7 - Compare source selectable from any axis
// R8 - Error drives output low and LED on
// R9 - Errors: following fault, reset low, self-reset
// R10 - Forty extended points, direction per eight
// R11 - Rack use needs groups five, nine inputs
// R12 - Outputs hold and read back last write
module motion_ctrl_digital_io #(
	parameter int AXES = 8
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic [3:0]           axis_count,
	input  wire logic [AXES-1:0]      stepper_mode,
	input  wire logic [AXES-1:0]      aux_chan_a_plus,
	input  wire logic [AXES-1:0]      aux_chan_b_plus,
	input  wire logic [6:0]           input_index,
	output logic                      input_value,
	output logic                      input_available,
	input  wire dio_pkg::out_cmd_t    out_cmd,
	output logic [15:0]               general_out,
	output logic [15:0]               bank_readback_operand,
	input  wire dio_pkg::cmp_cfg_t    compare_arming_command,
	input  wire logic [AXES*32-1:0]   axis_position,
	output logic                      compare_strobe_out,
	input  wire logic [AXES-1:0]      following_fault,
	input  wire logic                 reset_line_n,
	input  wire logic                 self_reset,
	output logic                      error_out_n,
	output logic                      status_led,
	input  wire logic [`EXT_GROUPS-1:0] extended_bank_direction,
	input  wire logic [`EXT_POINTS-1:0] ext_in,
	input  wire logic [`EXT_POINTS-1:0] ext_out_value,
	output logic [`EXT_POINTS-1:0]    ext_out,
	output logic [`EXT_POINTS-1:0]    ext_oe,
	output logic [`EXT_POINTS-1:0]    ext_read
);
	import dio_pkg::*;

	localparam int PULSE_CYC = `STROBE_PULSE_CYCLES;

	typedef struct packed {
		logic [AXES-1:0]        a_meta;
		logic [AXES-1:0]        a_sync;
		logic [AXES-1:0]        b_meta;
		logic [AXES-1:0]        b_sync;
		logic [`EXT_POINTS-1:0] ext_meta;
		logic [`EXT_POINTS-1:0] ext_sync;
		logic [2:0]             err_meta;
		logic [2:0]             err_sync;
		logic                   in_val;
		logic                   in_ok;
		logic [15:0]            outs;
		logic                   armed;
		logic [31:0]            target;
		logic [7:0]             pulse_cnt;
		logic                   strobe;
		logic                   err_n;
		logic                   led;
		logic [`EXT_POINTS-1:0] xo;
		logic [`EXT_POINTS-1:0] xoe;
	} state_t;

	state_t st;
	state_t next_st;
	logic [`EXT_POINTS-1:0] group_oe;
	logic [31:0] sel_pos;
	logic second_bank;
	logic [6:0] rel_idx;
	logic [2:0] ax;

	// -------------------------------------------------------------
	// Extended bank direction per group
	// -------------------------------------------------------------
	for (genvar g = 0; g < `EXT_GROUPS; g++)
	begin : g_grp
		assign group_oe[g*8 +: 8] = {8{extended_bank_direction[g]}}; // see R10
	end

	always_comb
	begin
		next_st = st;
		// Aux, extended, reset-line and self-reset pins pass two flops before use
		next_st.a_meta = aux_chan_a_plus;
		next_st.a_sync = st.a_meta;
		next_st.b_meta = aux_chan_b_plus;
		next_st.b_sync = st.b_meta;
		next_st.ext_meta = ext_in;
		next_st.ext_sync = st.ext_meta;
		next_st.err_meta = {self_reset, ~reset_line_n, 1'b0};
		next_st.err_sync = st.err_meta;

		// ---------------------------------------------------------
		// Aux encoder inputs as general inputs
		// ---------------------------------------------------------
		rel_idx = input_index - `AUX_BASE_INDEX;
		ax = rel_idx[3:1];
		next_st.in_val = 1'b0;
		next_st.in_ok = 1'b0;
		if (input_index >= `AUX_BASE_INDEX && input_index <= `AUX_LAST_INDEX
			&& 32'(ax) < AXES) // see R1
		begin
			// Even offset is channel A, so 81 is A and 82 is B of axis 0
			next_st.in_ok = ~stepper_mode[ax]; // see R3
			next_st.in_val = ~stepper_mode[ax]
				& (rel_idx[0] ? st.b_sync[ax] : st.a_sync[ax]); // see R2
		end

		// ---------------------------------------------------------
		// General outputs
		// ---------------------------------------------------------
		second_bank = axis_count >= `SECOND_BANK_AXES; // see R5
		if (out_cmd.valid && (!out_cmd.bank || second_bank))
		begin
			unique case (out_cmd.op) // see R4
				out_raise:      next_st.outs[{out_cmd.bank, out_cmd.bit_sel}] = 1'b1;
				out_lower:      next_st.outs[{out_cmd.bank, out_cmd.bit_sel}] = 1'b0;
				out_write_bit:  next_st.outs[{out_cmd.bank, out_cmd.bit_sel}] = out_cmd.data[0];
				out_write_bank: next_st.outs[out_cmd.bank*8 +: 8] = out_cmd.data;
			endcase
		end
		if (!second_bank)
			next_st.outs[15:8] = `OUT_RESET; // Absent bank stays quiet

		// ---------------------------------------------------------
		// Compare output
		// ---------------------------------------------------------
		sel_pos = axis_position[compare_arming_command.axis_sel*32 +: 32]; // see R7
		next_st.strobe = 1'b1;
		if (st.pulse_cnt != 8'h00)
		begin
			next_st.pulse_cnt = st.pulse_cnt - 8'h01;
			next_st.strobe = 1'b0;
		end
		if (compare_arming_command.arm)
		begin
			next_st.armed = 1'b1;
			next_st.target = compare_arming_command.point;
		end
		else if (st.armed && $signed(sel_pos) >= $signed(st.target)) // see R6
		begin
			// Firing cycle counts as the first low cycle
			next_st.pulse_cnt = 8'(PULSE_CYC - 1);
			next_st.strobe = 1'b0;
			if (compare_arming_command.mode == cmp_incremental)
				next_st.target = st.target + compare_arming_command.increment;
			else
				next_st.armed = 1'b0; // One-shot disarms after firing
		end

		// ---------------------------------------------------------
		// Error output
		// ---------------------------------------------------------
		next_st.err_n = ~(|following_fault | |st.err_sync); // see R9
		next_st.led = ~next_st.err_n; // see R8

		// Extended drive follows direction; pins read back always
		next_st.xoe = group_oe;
		next_st.xo = ext_out_value & group_oe;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st <= '0;
			st.outs <= {`OUT_RESET, `OUT_RESET};
			st.strobe <= 1'b1;
			st.err_n <= 1'b0; // Reset itself is an error condition
			st.led <= 1'b1;
		end
		else
			st <= next_st;
	end

	assign input_value = st.in_val;
	assign input_available = st.in_ok;
	assign general_out = st.outs;
	assign bank_readback_operand = st.outs; // see R12
	assign compare_strobe_out = st.strobe;
	assign error_out_n = st.err_n;
	assign status_led = st.led;
	assign ext_out = st.xo;
	assign ext_oe = st.xoe;
	assign ext_read = st.ext_sync;

	// -------------------------------------------------------------
	// Checks
	// -------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_led_tracks_error: assert property (status_led == !error_out_n) // see R8
		else $error("LED disagrees with error output");
	a_fault_drives_low: assert property (|following_fault |=> !error_out_n) // see R9
		else $error("Following fault did not raise error");
	a_pulse_width: assert property ($fell(compare_strobe_out) |-> !compare_strobe_out[*8]) // see R6
		else $error("Compare pulse too short");
	a_raise_sets_bit: assert property (out_cmd.valid && out_cmd.op == out_raise && !out_cmd.bank
		|=> general_out[$past(out_cmd.bit_sel)]) // see R4
		else $error("Raise did not set output");
	a_bank_hold: assert property (!out_cmd.valid && axis_count >= 4'h5 |=> $stable(general_out)) // see R12
		else $error("Outputs changed without write");
	a_no_second_bank: assert property (axis_count < 4'h5 |=> general_out[15:8] == 8'h00) // see R5
		else $error("Second bank active with few axes");
	a_stepper_hides: assert property (input_index == 7'h51 && stepper_mode[0]
		|=> !input_available) // see R3
		else $error("Stepper aux input offered");
	a_ext_direction: assert property (ext_oe[7:0] == {8{$past(extended_bank_direction[0])}}) // see R10
		else $error("Extended direction wrong");

	c_pulse: cover property ($fell(compare_strobe_out));
	c_error: cover property ($fell(error_out_n));
	c_aux_read: cover property (input_available && input_value);
	c_bank2: cover property (out_cmd.valid && out_cmd.bank && axis_count >= 4'h5);
endmodule

// ### bench/dio_sensor_rack.sv
// Sensor and relay rack model on the extended bank pins
`timescale 1ns/10ps
module dio_sensor_rack (
	input  wire logic [39:0] ext_out,
	input  wire logic [39:0] ext_oe,
	input  wire logic [39:0] sensor,
	output logic      [39:0] ext_in
);
	// Pin level: block wins where it drives, sensor elsewhere
	assign ext_in = (ext_out & ext_oe) | (sensor & ~ext_oe);
endmodule

// ### bench/motion_ctrl_digital_io_bench.sv
// Bench for the motion controller digital I/O block
`timescale 1ns/10ps
module motion_ctrl_digital_io_bench;
	import dio_pkg::*;
	logic clk = 0, rst_n = 0, reset_line_n = 1, self_reset = 0;
	logic iv, ia, strobe, err_n, led;
	logic [3:0] axis_count = 8;
	logic [7:0] step = 0, aux_a = 0, aux_b = 0, fault = 0;
	logic [6:0] idx = 0;
	logic [15:0] gout, rb;
	logic [255:0] pos = 0;
	logic [4:0] dir = 0;
	logic [39:0] ext_in, val = 0, sensor = 0, eout, eoe, eread;
	out_cmd_t cmd = '0;
	cmp_cfg_t cfg = '0;
	int err_total = 0, checks_done = 0, n;
	motion_ctrl_digital_io #(.AXES(8)) dut (.clk(clk), .rst_n(rst_n),
		.axis_count(axis_count), .stepper_mode(step), .aux_chan_a_plus(aux_a),
		.aux_chan_b_plus(aux_b), .input_index(idx), .input_value(iv),
		.input_available(ia), .out_cmd(cmd), .general_out(gout),
		.bank_readback_operand(rb), .compare_arming_command(cfg), .axis_position(pos),
		.compare_strobe_out(strobe), .following_fault(fault), .reset_line_n(reset_line_n),
		.self_reset(self_reset), .error_out_n(err_n), .status_led(led),
		.extended_bank_direction(dir), .ext_in(ext_in), .ext_out_value(val),
		.ext_out(eout), .ext_oe(eoe), .ext_read(eread));
	dio_sensor_rack rack (.ext_out(eout), .ext_oe(eoe), .sensor(sensor), .ext_in(ext_in));
	initial forever #5 clk = ~clk;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task chk(input string nm, input logic [39:0] e, input logic [39:0] g);
		checks_done++;
		if (g !== e)
		begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Valid stays high between back-to-back commands
	task put(input out_op_t op, input logic b, input logic [2:0] s, input logic [7:0] d);
		cmd = '{1'b1, op, b, s, d};
		tick(1);
	endtask
	task aux(input logic [6:0] i, input logic a, input logic v);
		idx = i;
		tick(2);
		chk("input_available", a, ia);
		chk("input_value", v, iv);
	endtask
	task err(input logic [7:0] f, input logic r, input logic s, input logic e);
		fault = f;
		reset_line_n = r;
		self_reset = s;
		tick(4);
		chk("error_out_n", e, err_n);
		chk("status_led", !e, led);
	endtask
	// Bounded wait for the low pulse, then its length
	task pulse(input int e);
		n = 0;
		while (strobe !== 1'b0 && n < 30)
		begin
			tick(1);
			n++;
		end
		if (n == 30)
		begin
			err_total++;
			print_verdict;
		end
		n = 0;
		while (strobe === 1'b0 && n < 200)
		begin
			tick(1);
			n++;
		end
		chk("pulse cycles", e, n);
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		tick(2);
		chk("strobe in reset", 1, strobe);
		chk("ext_oe in reset", 0, eoe);
		rst_n = 1;
		put(out_raise, 0, 3, 0);
		put(out_write_bank, 1, 0, 8'ha5);
		put(out_write_bit, 0, 0, 1);
		put(out_lower, 0, 3, 0);
		cmd.valid = 0;
		tick(1);
		chk("general_out", 16'ha501, gout);
		tick(5);
		chk("readback", 16'ha501, rb);
		axis_count = 4;
		put(out_write_bank, 1, 0, 8'hff);
		cmd.valid = 0;
		tick(2);
		chk("general_out", 16'h0001, gout);
		$display("test outputs done");
		aux_a = 8'h01;
		aux_b = 8'h80;
		axis_count = 8;
		tick(3);
		aux(7'h51, 1, 1);
		aux(7'h52, 1, 0);
		aux(7'h60, 1, 1);
		aux(7'h50, 0, 0);
		step = 8'h01;
		aux(7'h51, 0, 0);
		$display("test aux done");
		err(8'h04, 1, 0, 0);
		err(0, 1, 0, 1);
		err(0, 0, 0, 0);
		err(0, 1, 1, 0);
		err(0, 1, 0, 1);
		$display("test error done");
		pos[31:0] = 500;
		pos[96+:32] = 50;
		cfg = '{1'b1, cmp_one_shot, 3'h3, 32'd100, 32'd0};
		tick(1);
		cfg.arm = 0;
		tick(5);
		chk("strobe idle", 1, strobe);
		pos[96+:32] = 200;
		pulse(60);
		n = 0;
		repeat (80)
		begin
			tick(1);
			n += !strobe;
		end
		chk("one shot", 0, n);
		cfg = '{1'b1, cmp_incremental, 3'h3, 32'd300, 32'd100};
		tick(1);
		cfg.arm = 0;
		pos[96+:32] = 300;
		pulse(60);
		pos[96+:32] = 400;
		pulse(60);
		$display("test compare done");
		// Group 0 set as output, then only sensor group 4 set as output
		dir = 5'h01;
		val = 40'h5a;
		sensor = 40'hc3_0000_0000;
		tick(5);
		chk("ext_oe", 40'hff, eoe);
		chk("ext_out", 40'h5a, eout & eoe);
		chk("ext_read", 40'hc3_0000_005a, eread);
		dir = 5'h10;
		tick(2);
		chk("ext_oe", 40'hff_0000_0000, eoe);
		$display("test extended done");
		print_verdict;
	end
endmodule
